//--- src/pcrr_top.sv
// How it works
// - With clock PM enabled and link in L1, release the clock request high.
// - After release, any park delay from zero upward is tolerated.
// - After requesting, tolerate the clock staying parked for a while.
// - Reported L1 exit latency includes clock request and restore time.
// - Release only after all attached links reached L1.Idle.
// - Assert clock request on receiver electrical idle exit.
// - Assert clock request together with transmitter idle exit.
// - Work correctly if the reference clock is never parked.
// - Also release the clock request in L2 or L3.
// - Advertise clock PM support in the link capability word.
// - Clock PM enabled by default at power-up and each warm reset.
// - Reset line warm-resets; functions initialise on release, reset while held.
// - Provide an open-drain wake request output when wake is supported.
// - With clock PM disabled keep request asserted except in L1 substates; the code also releases it in L2 or L3.
// - Hold the clock request asserted while platform reset is asserted.
// - Clock request treated as asynchronous to the reference clock.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcrr_top #(
  parameter int          STABLE_CYC    = pcrr_pkg::CLK_STABLE_CYC,
  parameter int          GAP_CYC       = pcrr_pkg::REFCLK_GAP_CYC,
  parameter logic [2:0]  L1_EXIT_LAT   = pcrr_pkg::L1_EXIT_LAT_RST,
  parameter bit          WAKE_SUPPORT  = 1'b1
) (
  input  wire logic               i_clk,
  input  wire logic               i_reset_n,
  // Wishbone classic slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [31:0]        i_wb_dat,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  // Link state from the protocol engine
  input  wire pcrr_pkg::pcrr_link_s i_link,
  input  wire logic               i_wake_event,
  // Pins
  input  wire logic               i_perst_n,
  input  wire logic               i_refclk,
  input  wire logic               i_clkreq_n_in,
  output logic                    o_clkreq_n_out,
  output logic                    o_clkreq_n_oe,
  input  wire logic               i_pcie_wake_request_n_in,
  output logic                    o_pcie_wake_request_n_out,
  output logic                    o_pcie_wake_request_n_oe,
  // Function reset towards the rest of the adapter
  output logic                    o_func_reset,
  output logic                    o_func_init
);

  pcrr_pkg::pcrr_state_e state_r;
  pcrr_pkg::pcrr_state_e state_nxt;

  logic [1:0]  perst_sync_r;
  logic [1:0]  clkreq_sync_r;
  logic [1:0]  refclk_sync_r;
  logic [1:0]  wline_sync_r;
  logic        refclk_prev_r;
  logic        perst_asserted;
  logic        refclk_edge;
  logic [15:0] link_ctrl_r;
  logic [1:0]  aux_ctrl_r;
  logic [7:0]  gap_cnt_r;
  logic        refclk_active_r;
  logic [15:0] stable_cnt_r;
  logic        stable_ok;
  logic [7:0]  lat_cnt_r;
  logic [7:0]  lat_last_r;
  logic        lat_run_r;
  logic        slow_flag_r;
  logic        unstable_flag_r;
  logic        wake_pend_r;
  logic        release_ok;
  logic        force_req;
  logic        wb_req;
  logic        wb_done;
  logic        wr_status;
  logic        wr_aux;
  logic [31:0] link_cap;
  logic [31:0] status_word;
  logic [31:0] rd_data;

  // Pin synchronisers; first stage is read only by the second
  // two-flop synchronise
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      perst_sync_r  <= 2'h0;
      clkreq_sync_r <= 2'h0;
      refclk_sync_r <= 2'h0;
      wline_sync_r  <= 2'h0;
    end else begin
      perst_sync_r  <= {perst_sync_r[0], i_perst_n};
      clkreq_sync_r <= {clkreq_sync_r[0], i_clkreq_n_in};
      refclk_sync_r <= {refclk_sync_r[0], i_refclk};
      wline_sync_r  <= {wline_sync_r[0], i_pcie_wake_request_n_in};
    end
  end

  assign perst_asserted = ~perst_sync_r[1];

  // Reference clock sampled as data; an edge is any change of the synced level
  // refclk is never used as a clock here
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refclk_prev_r <= 1'b0;
    end else begin
      refclk_prev_r <= refclk_sync_r[1];
    end
  end

  assign refclk_edge = refclk_prev_r ^ refclk_sync_r[1];

  // Activity detector: clock counts as active while edges keep coming
  // works whether or not the clock ever parks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_cnt_r       <= 8'h00;
      refclk_active_r <= 1'b0;
    end else if (refclk_edge) begin
      gap_cnt_r       <= 8'h00;
      refclk_active_r <= 1'b1;
    end else if (gap_cnt_r >= 8'(GAP_CYC)) begin
      refclk_active_r <= 1'b0;
    end else begin
      gap_cnt_r <= gap_cnt_r + 8'h01;
    end
  end

  // Cycles of continuous activity, saturating
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stable_cnt_r <= 16'h0000;
    end else if (!refclk_active_r) begin
      stable_cnt_r <= 16'h0000;
    end else if (!stable_ok) begin
      stable_cnt_r <= stable_cnt_r + 16'h0001;
    end
  end

  assign stable_ok = stable_cnt_r >= 16'(STABLE_CYC);

  // Immediate request terms bypass the state so exit is not delayed
  // receiver idle break
  assign force_req = i_link.rx_idle_break | i_link.tx_idle_break;

  // Release permission; the engine's pending work keeps the clock alive
  // all links in L1.Idle
  // clock PM enable gates the L1.Idle release
  assign release_ok = ~i_link.tx_pending & ~force_req &
                      ((link_ctrl_r[pcrr_pkg::CTRL_CPM_EN_BIT] & i_link.l1_idle_all) |
                       i_link.l23 | i_link.l1_substate);

  // Clock request state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pcrr_pkg::CR_RESET: begin
        if (!perst_asserted) begin
          state_nxt = pcrr_pkg::CR_ACTIVE;
        end
      end
      pcrr_pkg::CR_ACTIVE: begin
        if (perst_asserted) begin
          state_nxt = pcrr_pkg::CR_RESET;
        end else if (release_ok) begin
          state_nxt = pcrr_pkg::CR_RELEASED;
        end
      end
      pcrr_pkg::CR_RELEASED: begin
        if (perst_asserted) begin
          state_nxt = pcrr_pkg::CR_RESET;
        end else if (!release_ok) begin
          state_nxt = pcrr_pkg::CR_ACTIVE;
        end
      end
      default: begin
        state_nxt = pcrr_pkg::CR_RESET;
      end
    endcase
  end

  // no wait on parking after release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= pcrr_pkg::CR_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Open drain drive: enable pulls the line low
  // held low in reset
  assign o_clkreq_n_out = 1'b0;
  assign o_clkreq_n_oe  = (state_r != pcrr_pkg::CR_RELEASED) | force_req;

  // Function reset and one-cycle init pulse on release
  // hardware reset while held, init on release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_func_reset <= 1'b1;
      o_func_init  <= 1'b0;
    end else begin
      o_func_reset <= perst_asserted;
      o_func_init  <= (state_r == pcrr_pkg::CR_RESET) && !perst_asserted;
    end
  end

  // Restore latency from request to clock activity; the limit only binds without LTR
  // 400 ns restore check
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lat_run_r  <= 1'b0;
      lat_cnt_r  <= 8'h00;
      lat_last_r <= 8'h00;
    end else if (state_r == pcrr_pkg::CR_RELEASED && state_nxt == pcrr_pkg::CR_ACTIVE) begin
      lat_run_r <= 1'b1;
      lat_cnt_r <= 8'h00;
    end else if (lat_run_r && refclk_active_r) begin
      lat_run_r  <= 1'b0;
      lat_last_r <= lat_cnt_r;
    end else if (lat_run_r && lat_cnt_r != 8'hFF) begin
      lat_cnt_r <= lat_cnt_r + 8'h01;
    end
  end

  // Sticky slow-restore flag; a new event wins over a software clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_flag_r <= 1'b0;
    end else if (lat_run_r && !refclk_active_r && lat_cnt_r == 8'(pcrr_pkg::REQ_TO_ACTIVE_CYC)
                 && !aux_ctrl_r[pcrr_pkg::AUX_LTR_EN_BIT]) begin
      slow_flag_r <= 1'b1;
    end else if (wr_status && i_wb_sel[0] && i_wb_dat[pcrr_pkg::ST_SLOW_BIT]) begin
      slow_flag_r <= 1'b0;
    end
  end

  // Reset released without a long enough stable clock
  // stable clock before release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unstable_flag_r <= 1'b0;
    end else if (state_r == pcrr_pkg::CR_RESET && !perst_asserted && !stable_ok) begin
      unstable_flag_r <= 1'b1;
    end else if (wr_status && i_wb_sel[0] && i_wb_dat[pcrr_pkg::ST_UNSTABLE_BIT]) begin
      unstable_flag_r <= 1'b0;
    end
  end

  // Wake request held until software clears it; event wins over clear
  // open-drain wake output
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_pend_r <= 1'b0;
    end else if (WAKE_SUPPORT && i_wake_event) begin
      wake_pend_r <= 1'b1;
    end else if (wr_status && i_wb_sel[0] && i_wb_dat[pcrr_pkg::ST_WAKE_BIT]) begin
      wake_pend_r <= 1'b0;
    end
  end

  assign o_pcie_wake_request_n_out = 1'b0;
  assign o_pcie_wake_request_n_oe  = WAKE_SUPPORT &
                                     (wake_pend_r | aux_ctrl_r[pcrr_pkg::AUX_WAKE_BIT]);

  // Bus request decode; ack is registered so each access takes one wait
  // Writes land on the edge where the master sees ack high, so both agree on it
  assign wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_done   = i_wb_cyc & i_wb_stb & o_wb_ack;
  assign wr_status = wb_done & i_wb_we & (i_wb_adr == pcrr_pkg::OFS_STATUS);
  assign wr_aux    = wb_done & i_wb_we & (i_wb_adr == pcrr_pkg::OFS_AUX_CTRL);

  // Link control; warm reset restores the enable default
  // enabled at power-up and warm reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_ctrl_r <= pcrr_pkg::LINK_CTRL_RST;
    end else if (perst_asserted) begin
      link_ctrl_r <= pcrr_pkg::LINK_CTRL_RST;
    end else if (wb_done && i_wb_we && i_wb_adr == pcrr_pkg::OFS_LINK_CTRL) begin
      if (i_wb_sel[0]) begin
        link_ctrl_r[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        link_ctrl_r[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // Auxiliary control: LTR enable and software wake
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aux_ctrl_r <= pcrr_pkg::AUX_CTRL_RST;
    end else if (wr_aux && i_wb_sel[0]) begin
      aux_ctrl_r <= i_wb_dat[1:0];
    end
  end

  // Capability word; the latency code must already include clock restore time
  // clock PM supported
  always_comb begin
    link_cap = 32'h0000_0000;
    link_cap[pcrr_pkg::CAP_CPM_BIT] = 1'b1;
    link_cap[pcrr_pkg::CAP_L1LAT_LO +: 3] = L1_EXIT_LAT;
  end

  // Status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pcrr_pkg::ST_DRIVE_BIT]    = o_clkreq_n_oe;
    status_word[pcrr_pkg::ST_LINE_BIT]     = ~clkreq_sync_r[1];
    status_word[pcrr_pkg::ST_REFCLK_BIT]   = refclk_active_r;
    status_word[pcrr_pkg::ST_PERST_BIT]    = perst_asserted;
    status_word[pcrr_pkg::ST_SLOW_BIT]     = slow_flag_r;
    status_word[pcrr_pkg::ST_UNSTABLE_BIT] = unstable_flag_r;
    status_word[pcrr_pkg::ST_WAKE_BIT]     = wake_pend_r;
    status_word[pcrr_pkg::ST_WLINE_BIT]    = ~wline_sync_r[1];
    status_word[pcrr_pkg::ST_LAT_LO +: 8]  = lat_last_r;
  end

  // Read mux; unmapped addresses read zero and still ack
  always_comb begin
    unique case (i_wb_adr)
      pcrr_pkg::OFS_LINK_CAP:  rd_data = link_cap;
      pcrr_pkg::OFS_LINK_CTRL: rd_data = {16'h0000, link_ctrl_r};
      pcrr_pkg::OFS_STATUS:    rd_data = status_word;
      pcrr_pkg::OFS_AUX_CTRL:  rd_data = {30'h0000_0000, aux_ctrl_r};
      default:                 rd_data = 32'h0000_0000;
    endcase
  end

  // Ack and read data registered together
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= rd_data;
      end
    end
  end

endmodule

`default_nettype wire

//--- src/pcrr_pkg.sv
package pcrr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_LINK_CAP  = 8'h0C;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_AUX_CTRL  = 8'h18;

  // Field positions
  localparam int CAP_CPM_BIT     = 18;
  localparam int CAP_L1LAT_LO    = 15;
  localparam int CTRL_CPM_EN_BIT = 8;
  localparam int AUX_LTR_EN_BIT  = 0;
  localparam int AUX_WAKE_BIT    = 1;
  localparam int ST_DRIVE_BIT    = 0;
  localparam int ST_LINE_BIT     = 1;
  localparam int ST_REFCLK_BIT   = 2;
  localparam int ST_PERST_BIT    = 3;
  localparam int ST_SLOW_BIT     = 4;
  localparam int ST_UNSTABLE_BIT = 5;
  localparam int ST_WAKE_BIT     = 6;
  localparam int ST_WLINE_BIT    = 7;
  localparam int ST_LAT_LO       = 8;

  // Reset values
  localparam logic [15:0] LINK_CTRL_RST = 16'h0100;
  localparam logic [1:0]  AUX_CTRL_RST  = 2'h0;
  localparam logic [2:0]  L1_EXIT_LAT_RST = 3'h6;

  // Timing
  localparam int CLK_PERIOD_NS       = 20;
  localparam int REQ_TO_ACTIVE_NS    = 400;
  localparam int REQ_TO_ACTIVE_CYC   = REQ_TO_ACTIVE_NS / CLK_PERIOD_NS;
  localparam int RELEASE_TO_PARK_NS  = 0;
  localparam int REFCLK_GAP_NS       = 320;
  localparam int REFCLK_GAP_CYC      = REFCLK_GAP_NS / CLK_PERIOD_NS;
  localparam int CLK_STABLE_US       = 100;
  localparam int CLK_STABLE_CYC      = (CLK_STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clock request states
  typedef enum logic [1:0] {
    CR_RESET,
    CR_ACTIVE,
    CR_RELEASED
  } pcrr_state_e;

  // Link state from the protocol engine, same clock
  typedef struct packed {
    logic l1_idle_all;
    logic l23;
    logic l1_substate;
    logic rx_idle_break;
    logic tx_idle_break;
    logic tx_pending;
  } pcrr_link_s;

endpackage

//--- sim/pcrr_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcrr_props (
  input wire logic                 i_clk,
  input wire logic                 i_reset_n,
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 o_wb_ack,
  input wire pcrr_pkg::pcrr_link_s i_link,
  input wire logic                 i_perst_n,
  input wire logic                 o_clkreq_n_out,
  input wire logic                 o_clkreq_n_oe,
  input wire logic                 o_pcie_wake_request_n_out,
  input wire logic                 o_func_reset,
  input wire logic                 o_func_init
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Two sync flops plus the state register give three edges
  perst_holds_req_a: assert property (!i_perst_n [*3] |=> o_clkreq_n_oe)
    else $error("request not held under reset");
  rx_break_req_a: assert property (i_link.rx_idle_break |-> o_clkreq_n_oe)
    else $error("rx idle exit without request");
  tx_break_req_a: assert property (i_link.tx_idle_break |-> o_clkreq_n_oe)
    else $error("tx idle exit without request");
  pending_req_a: assert property (i_link.tx_pending [*2] |-> o_clkreq_n_oe)
    else $error("request released with pending traffic");
  // A release needs an idle link state on the edge before
  release_cause_a: assert property (
    $fell(o_clkreq_n_oe) |-> $past(i_link.l1_idle_all | i_link.l23 | i_link.l1_substate) && !$past(i_link.tx_pending))
    else $error("release without idle link");
  func_reset_a: assert property (!i_perst_n [*3] |=> o_func_reset)
    else $error("function reset missing");
  init_pulse_a: assert property (o_func_init |=> !o_func_init && !o_func_reset)
    else $error("init pulse too long");
  // Released pin is never driven high by the block
  open_drain_a: assert property (!o_clkreq_n_out && !o_pcie_wake_request_n_out)
    else $error("open drain pin driven high");
  sync_delay_a: assert property ($rose(i_perst_n) |=> o_func_reset)
    else $error("reset pin not synchronised");
  cover property ($fell(o_clkreq_n_oe));
  cover property (o_func_init);
  cover property (i_wb_cyc && i_wb_stb && o_wb_ack);
endmodule
`default_nettype wire

//--- sim/pcrr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcrr_host #(
  parameter int MIN_ASSERT_NS = 100000
) (
  input  wire logic       i_clkreq_n,
  input  wire logic       i_park_en,
  input  wire logic       i_hold_perst,
  input  wire logic [8:0] i_restore_ns,
  output logic            o_refclk,
  output logic            o_perst_n
);
  logic run = 1'b1;
  initial o_refclk = 1'b0;
  // Reference clock stands still while parked
  always begin
    #80;
    if (run) o_refclk = ~o_refclk;
  end
  // Parking is optional, so a release may be ignored
  always @(posedge i_clkreq_n) if (i_park_en && o_perst_n) run = 1'b0;
  // restore within 400 ns, LTR off so no extra delay
  always @(negedge i_clkreq_n) begin
    #(i_restore_ns);
    run = 1'b1;
  end
  // shortened rails delay, held 100 us, clock on
  always begin
    o_perst_n = 1'b0;
    run = 1'b1;
    #(MIN_ASSERT_NS);
    wait (!i_hold_perst);
    o_perst_n = 1'b1;
    wait (i_hold_perst);
  end
endmodule
`default_nettype wire

//--- sim/tb_pcie_clock_request_reset.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_clock_request_reset;
  logic                 i_clk = 1'b0;
  logic                 i_reset_n = 1'b0;
  logic                 cyc = 1'b0;
  logic                 stb = 1'b0;
  logic                 we = 1'b0;
  logic [7:0]           adr = 8'h00;
  logic [31:0]          wdat = 32'h0;
  logic [31:0]          rdat;
  logic [31:0]          q;
  logic                 ack;
  pcrr_pkg::pcrr_link_s link = '0;
  logic                 wake_ev = 1'b0;
  logic                 park_en = 1'b0;
  logic                 hold = 1'b0;
  logic [8:0]           rns = 9'h000;
  logic [15:0]          s = 16'hCF00;
  logic                 refclk, perst_n, oe, cout, woe, wout, freset, finit;
  wire                  cline = oe ? 1'b0 : 1'b1;
  wire                  wline = woe ? 1'b0 : 1'b1;
  int                   n_fail = 0;
  int                   checks = 0;
  int                   cyc_n = 0;
  always #10 i_clk = ~i_clk;
  pcrr_top #(.STABLE_CYC(20)) DUT (.i_clk, .i_reset_n, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_link(link),
    .i_wake_event(wake_ev), .i_perst_n(perst_n), .i_refclk(refclk), .i_clkreq_n_in(cline),
    .o_clkreq_n_out(cout), .o_clkreq_n_oe(oe), .i_pcie_wake_request_n_in(wline),
    .o_pcie_wake_request_n_out(wout), .o_pcie_wake_request_n_oe(woe), .o_func_reset(freset),
    .o_func_init(finit));
  pcrr_host HOST (.i_clkreq_n(cline), .i_park_en(park_en), .i_hold_perst(hold), .i_restore_ns(rns),
    .o_refclk(refclk), .o_perst_n(perst_n));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Classic cycle held until ack is sampled, data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_init;
    do @(posedge i_clk); while (finit !== 1'b1);
    #1;
    chk(finit, 0);
    chk(freset, 0);
  endtask
  // Random link states against the release equation; parks and restore delays of 0 to 300 ns mixed in
  task automatic run_link(input logic cpm);
    pcrr_pkg::pcrr_link_s v;
    for (int i = 0; i < 60; i++) begin
      s = lfsr(s);
      v = s[5:0];
      @(posedge i_clk);
      link <= v;
      park_en <= s[6];
      rns <= 9'(s[8:7]) * 9'd100;
      repeat (2) @(posedge i_clk);
      #1;
      chk(oe, !(!v.tx_pending && !v.rx_idle_break && !v.tx_idle_break
        && ((cpm && v.l1_idle_all) || v.l23 || v.l1_substate)));
    end
    link <= '0;
  endtask
  task automatic close_out;
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard well above the two 100 us reset holds
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    chk(oe, 1);
    chk(freset, 1);
    wb(1'b0, pcrr_pkg::OFS_LINK_CAP, 32'h0);
    chk(q[18:15], {1'b1, pcrr_pkg::L1_EXIT_LAT_RST});
    wb(1'b0, pcrr_pkg::OFS_LINK_CTRL, 32'h0);
    chk(q, 32'(pcrr_pkg::LINK_CTRL_RST));
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 0);
    wait_init();
    run_link(1'b1);
    wb(1'b1, pcrr_pkg::OFS_LINK_CTRL, 32'h0);
    run_link(1'b0);
    // Warm reset must bring the clock PM enable back
    @(posedge i_clk);
    hold <= 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    chk(oe, 1);
    chk(freset, 1);
    hold <= 1'b0;
    wait_init();
    wb(1'b0, pcrr_pkg::OFS_LINK_CTRL, 32'h0);
    chk(q, 32'(pcrr_pkg::LINK_CTRL_RST));
    // Wake pin driven from software and the pending flag from an event
    wb(1'b1, pcrr_pkg::OFS_AUX_CTRL, 32'h2);
    #1;
    chk(woe, 1);
    wb(1'b1, pcrr_pkg::OFS_AUX_CTRL, 32'h0);
    #1;
    chk(woe, 0);
    @(posedge i_clk);
    wake_ev <= 1'b1;
    @(posedge i_clk);
    wake_ev <= 1'b0;
    // Wake line readback passes two sync flops before the status word shows it
    repeat (2) @(posedge i_clk);
    wb(1'b0, pcrr_pkg::OFS_STATUS, 32'h0);
    chk(q[pcrr_pkg::ST_WAKE_BIT], 1);
    chk(q[pcrr_pkg::ST_WLINE_BIT], 1);
    chk(q[pcrr_pkg::ST_UNSTABLE_BIT], 0);
    chk(q[pcrr_pkg::ST_REFCLK_BIT], 1);
    // Clearing the pending wake releases the pin
    wb(1'b1, pcrr_pkg::OFS_STATUS, 32'h40);
    #1;
    chk(woe, 0);
    close_out();
  end
endmodule
bind pcrr_top pcrr_props u_props (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_link, .i_perst_n,
  .o_clkreq_n_out, .o_clkreq_n_oe, .o_pcie_wake_request_n_out, .o_func_reset, .o_func_init);
`default_nettype wire
